// ===== ssv_pkg.sv
// Shared constants and types for the startup check and reset supervisor.
`default_nettype none
package ssv_pkg;
  // Clock rate and the one-millisecond tick that paces every timer.
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // Phase lengths in milliseconds.
  localparam int INIT_TIME_MS = 40;
  localparam int SYNC_PULSE_MS = 250;
  localparam int RST_PULSE_MS = 1;
  // Register byte offsets.
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_WD_TIMEOUT = 5'h04;
  localparam logic [4:0] ADDR_WD_START = 5'h08;
  localparam logic [4:0] ADDR_RST_DELAY = 5'h0c;
  localparam logic [4:0] ADDR_SEL = 5'h10;
  localparam logic [4:0] ADDR_KICK = 5'h14;
  localparam logic [4:0] ADDR_STATUS = 5'h18;
  localparam logic [4:0] ADDR_LOG_VALID = 5'h1c;
  // Control field positions and the input field of the select register.
  localparam int CTRL_WD_EN = 0;
  localparam int CTRL_WD_DLY = 1;
  localparam int CTRL_MERGE = 2;
  localparam int CTRL_PULSE = 3;
  localparam int CTRL_TRACK = 4;
  localparam int SEL_GPI_LSB = 8;
  // Status field positions; the low four are sticky.
  localparam int ST_CFG_FAIL = 0;
  localparam int ST_WD_TMO = 1;
  localparam int ST_LOG_FAIL = 2;
  localparam int ST_FW_FAIL = 3;
  localparam int ST_INIT = 4;
  localparam int ST_WD_RUN = 5;
  localparam int ST_RST_ON = 6;
  // Values after reset or after configuration is discarded.
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [15:0] WD_TIMEOUT_RESET = 16'h03e8;
  localparam logic [15:0] WD_START_RESET = 16'h03e8;
  localparam logic [15:0] RST_DELAY_RESET = 16'h000a;
  localparam logic [15:0] SEL_RESET = 16'h0000;

  typedef enum logic [3:0] {
    WD_OFF = 4'b0001,
    WD_WAIT = 4'b0010,
    WD_RUN = 4'b0100,
    WD_STOP = 4'b1000
  } ssv_wd_state_t;

  typedef enum logic [4:0] {
    RS_HOLD = 5'b00001,
    RS_DELAY = 5'b00010,
    RS_RELEASED = 5'b00100,
    RS_PULSE = 5'b01000,
    RS_ARMED = 5'b10000
  } ssv_rst_state_t;
endpackage
`default_nettype wire

// ===== ssv_down_timer.sv
// Loadable down counter that steps on a tick enable and flags zero.
`default_nettype none
module ssv_down_timer #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  input wire logic tick,
  output logic done
);
  logic [W-1:0] cnt_reg;

  // A load always wins over a tick in the same cycle.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= loadVal;
    end else if (tick && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Zero reads as done, so a fresh load shows one cycle later.
  assign done = (cnt_reg == '0);

  AST_TIMER_LOAD: assert property (@(posedge ref_clk) disable iff (!resetn)
    load |=> cnt_reg == $past(loadVal))
    else $error("Timer did not take the loaded value.");
endmodule
`default_nettype wire

// ===== ssv_toggle_sync.sv
// Two-stage synchroniser with a toggle detector on the settled level.
`default_nettype none
module ssv_toggle_sync (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic din,
  output logic toggled
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Only the second stage feeds the edge detector.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Either edge counts as a kick.
  assign toggled = sync_reg ^ last_reg;
endmodule
`default_nettype wire

// ===== ssv_supervisor.sv
// Startup checks, watchdog and system reset supervisor with Avalon-MM registers.
//
// Behaviour
// - Every kick toggle reloads the watchdog down count with the timeout value.
// - Host kicks within the timeout; otherwise the watchdog declares a timeout.
// - A timeout drives a pulse on the timeout output as reset request.
// - A kick register write acts exactly like a kick toggle; pins optional.
// - After timeout the watchdog stays stopped until the next kick.
// - Option picks immediate watchdog start or start after an initial wait.
// - Reset releases a delay after selected rails good and inputs asserted.
// - Reset asserts at once when a selected rail or input drops; in pulse mode a drop only re-arms.
// - Pulse mode emits one reset pulse when good is reached.
// - Merged watchdog timeout toggles reset with fixed or tracking release.
// - System reset output defaults to asserted.
// - Reconfiguring reset asserts it briefly before conditions are evaluated.
// - Each exit from reset runs a 40 ms initialisation phase.
// - Pins other than the sync clock stay high impedance during initialisation; normal work follows.
// - Firmware checksum checked at power-up; mismatch restarts the device.
// - While firmware fails, sync clock pin pulses with 250 ms width.
// - Configuration checksum failure discards configuration, flags and alerts.
// - Log entries failing their checksum are ignored; valid ones are kept.
// - Holding the reset pin low resets; release follows the pin going high.
// - Alert line asserts while any sticky status flag is set; only the four sticky flags drive it.
`default_nettype none
module ssv_supervisor
  import ssv_pkg::*;
#(
  parameter int NRAIL = 8,
  parameter int NGPI = 8,
  parameter int NLOG = 8,
  parameter int TICK_CYCLES_P = ssv_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic fwSumOk,
  input wire logic cfgSumOk,
  input wire logic [NLOG-1:0] logSumOk,
  input wire logic [NRAIL-1:0] railAboveOn,
  input wire logic [NRAIL-1:0] railBelowOff,
  input wire logic [NGPI-1:0] gpiIn,
  input wire logic kickIn,
  output logic timeoutOut,
  output logic timeoutOeN,
  output logic sysRstN,
  output logic sysRstOeN,
  output logic syncClkOut,
  output logic syncClkOeN,
  output logic alertN,
  output logic alertOeN
);
  import ssv_pkg::*;

  logic ack_reg;
  logic wrAcc;
  logic [31:0] rdMux;
  logic [31:0] tickCnt_reg;
  logic msTick;
  logic [4:0] ctrl_reg;
  logic [15:0] wdTimeout_reg;
  logic [15:0] wdStart_reg;
  logic [15:0] rstDelay_reg;
  logic [15:0] sel_reg;
  logic [3:0] sticky_reg;
  logic [NLOG-1:0] logValid_reg;
  logic initBusy_reg;
  logic startPend_reg;
  logic fwFailLoop_reg;
  logic initDone;
  logic initEnd;
  logic cfgClear;
  logic syncDone;
  logic kickPin;
  logic kick;
  logic reconfig;
  ssv_wd_state_t wdState_reg, wdState_next;
  logic wdLoad;
  logic [15:0] wdLoadVal;
  logic wdDone;
  logic wdTmo;
  logic timeoutPulse_reg;
  ssv_rst_state_t rsState_reg, rsState_next;
  logic rsLoad;
  logic [15:0] rsLoadVal;
  logic rsDone;
  logic condOk;
  logic condBad;
  logic pulseMode;
  logic rstAssert;
  logic sysRstN_reg;
  logic syncClk_reg;
  logic alertN_reg;

  // Bus answers one cycle after the request appears; waitrequest drops then.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wrAcc = avs_write && ack_reg;
  assign kick = kickPin || (wrAcc && avs_address == ADDR_KICK);
  assign reconfig = wrAcc && (avs_address == ADDR_CTRL || avs_address == ADDR_RST_DELAY
                    || avs_address == ADDR_SEL);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  // Read data is captured in the waiting cycle so it stands at the accepting edge.
  always_comb begin
    rdMux = 32'h0000_0000;
    case (avs_address)
      ADDR_CTRL: rdMux = {27'h0, ctrl_reg};
      ADDR_WD_TIMEOUT: rdMux = {16'h0, wdTimeout_reg};
      ADDR_WD_START: rdMux = {16'h0, wdStart_reg};
      ADDR_RST_DELAY: rdMux = {16'h0, rstDelay_reg};
      ADDR_SEL: rdMux = {16'h0, sel_reg};
      ADDR_STATUS: rdMux = {25'h0, rsState_reg != RS_RELEASED && rsState_reg != RS_ARMED,
                            wdState_reg == WD_RUN, initBusy_reg, sticky_reg};
      ADDR_LOG_VALID: rdMux = 32'(logValid_reg);
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      avs_readdata <= rdMux;
    end
  end

  // Millisecond tick; a bench may shorten the period through the parameter.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tickCnt_reg <= 32'h0000_0000;
    end else if (tickCnt_reg >= 32'(TICK_CYCLES_P - 1)) begin
      tickCnt_reg <= 32'h0000_0000;
    end else begin
      tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
    end
  end
  assign msTick = (tickCnt_reg >= 32'(TICK_CYCLES_P - 1));

  // Initialisation phase: the reset pin restarts it, a bad firmware sum repeats it.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      initBusy_reg <= 1'b1;
      startPend_reg <= 1'b1;
      fwFailLoop_reg <= 1'b0;
    end else if (startPend_reg) begin
      startPend_reg <= 1'b0;
    end else if (initEnd && !fwSumOk) begin
      startPend_reg <= 1'b1;
      fwFailLoop_reg <= 1'b1;
    end else if (initEnd) begin
      initBusy_reg <= 1'b0;
      fwFailLoop_reg <= 1'b0;
    end
  end
  assign initEnd = initBusy_reg && !startPend_reg && initDone;
  assign cfgClear = initEnd && (!fwSumOk || !cfgSumOk);

  ssv_down_timer #(.W(16)) initTimer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(startPend_reg),
    .loadVal(16'(INIT_TIME_MS)),
    .tick(msTick),
    .done(initDone)
  );

  // Sync clock toggles every pulse width while firmware keeps failing.
  ssv_down_timer #(.W(16)) syncTimer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(fwFailLoop_reg && syncDone),
    .loadVal(16'(SYNC_PULSE_MS)),
    .tick(msTick),
    .done(syncDone)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      syncClk_reg <= 1'b0;
    end else if (!fwFailLoop_reg) begin
      syncClk_reg <= 1'b0;
    end else if (syncDone) begin
      syncClk_reg <= !syncClk_reg;
    end
  end

  // Configuration registers; a failed sum falls back to the defaults.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RESET;
      wdTimeout_reg <= WD_TIMEOUT_RESET;
      wdStart_reg <= WD_START_RESET;
      rstDelay_reg <= RST_DELAY_RESET;
      sel_reg <= SEL_RESET;
    end else if (cfgClear) begin
      ctrl_reg <= CTRL_RESET;
      wdTimeout_reg <= WD_TIMEOUT_RESET;
      wdStart_reg <= WD_START_RESET;
      rstDelay_reg <= RST_DELAY_RESET;
      sel_reg <= SEL_RESET;
    end else if (wrAcc) begin
      case (avs_address)
        ADDR_CTRL: if (avs_byteenable[0]) ctrl_reg <= avs_writedata[4:0];
        ADDR_WD_TIMEOUT: begin
          if (avs_byteenable[0]) wdTimeout_reg[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) wdTimeout_reg[15:8] <= avs_writedata[15:8];
        end
        ADDR_WD_START: begin
          if (avs_byteenable[0]) wdStart_reg[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) wdStart_reg[15:8] <= avs_writedata[15:8];
        end
        ADDR_RST_DELAY: begin
          if (avs_byteenable[0]) rstDelay_reg[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) rstDelay_reg[15:8] <= avs_writedata[15:8];
        end
        ADDR_SEL: begin
          if (avs_byteenable[0]) sel_reg[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) sel_reg[15:8] <= avs_writedata[15:8];
        end
        default: ;
      endcase
    end
  end

  // Sticky flags: write one to clear, but a new event in the same cycle wins.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sticky_reg <= 4'h0;
    end else begin
      sticky_reg <= (sticky_reg & ~((wrAcc && avs_address == ADDR_STATUS
                     && avs_byteenable[0]) ? avs_writedata[3:0] : 4'h0))
                    | {initEnd && !fwSumOk,
                       initEnd && fwSumOk && !(&logSumOk),
                       wdTmo,
                       initEnd && fwSumOk && !cfgSumOk};
    end
  end

  // Only entries with a good checksum are kept as valid.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      logValid_reg <= '0;
    end else if (initEnd && fwSumOk) begin
      logValid_reg <= logSumOk;
    end
  end

  // Alert follows the sticky flags one cycle later.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      alertN_reg <= 1'b1;
    end else begin
      alertN_reg <= !(|sticky_reg);
    end
  end

  ssv_toggle_sync kickSync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .din(kickIn),
    .toggled(kickPin)
  );

  // Watchdog: the start wait and the running timeout count both end in a timeout.
  always_comb begin
    wdState_next = wdState_reg;
    wdLoad = 1'b0;
    wdLoadVal = wdTimeout_reg;
    wdTmo = 1'b0;
    if (initBusy_reg || !ctrl_reg[CTRL_WD_EN]) begin
      wdState_next = WD_OFF;
    end else begin
      unique case (wdState_reg)
        WD_OFF: begin
          wdLoad = 1'b1;
          if (ctrl_reg[CTRL_WD_DLY]) begin
            wdLoadVal = wdStart_reg;
            wdState_next = WD_WAIT;
          end else begin
            wdState_next = WD_RUN;
          end
        end
        WD_WAIT, WD_RUN: begin
          if (kick) begin
            wdLoad = 1'b1;
            wdState_next = WD_RUN;
          end else if (wdDone) begin
            wdTmo = 1'b1;
            wdState_next = WD_STOP;
          end
        end
        WD_STOP: begin
          if (kick) begin
            wdLoad = 1'b1;
            wdState_next = WD_RUN;
          end
        end
      endcase
    end
  end

  ssv_down_timer #(.W(16)) wdTimer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(wdLoad),
    .loadVal(wdLoadVal),
    .tick(msTick),
    .done(wdDone)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wdState_reg <= WD_OFF;
      timeoutPulse_reg <= 1'b0;
    end else begin
      wdState_reg <= wdState_next;
      timeoutPulse_reg <= wdTmo;
    end
  end

  // Release needs every selected rail good and every selected input high.
  assign condOk = &(railAboveOn | ~sel_reg[NRAIL-1:0])
                  && &(gpiIn | ~sel_reg[SEL_GPI_LSB +: NGPI]);
  assign condBad = |(railBelowOff & sel_reg[NRAIL-1:0])
                   || |(~gpiIn & sel_reg[SEL_GPI_LSB +: NGPI]);
  assign pulseMode = ctrl_reg[CTRL_PULSE];

  // System reset sequencing; a pulse mode releases in the armed state.
  always_comb begin
    rsState_next = rsState_reg;
    rsLoad = 1'b0;
    rsLoadVal = rstDelay_reg;
    if (initBusy_reg || reconfig) begin
      rsState_next = RS_HOLD;
    end else if (wdTmo && ctrl_reg[CTRL_MERGE] && rsState_reg != RS_HOLD) begin
      rsLoad = 1'b1;
      if (pulseMode) begin
        rsLoadVal = 16'(RST_PULSE_MS);
        rsState_next = RS_PULSE;
      end else if (ctrl_reg[CTRL_TRACK]) begin
        rsState_next = RS_HOLD;
      end else begin
        rsState_next = RS_DELAY;
      end
    end else begin
      unique case (rsState_reg)
        RS_HOLD: begin
          if (pulseMode) begin
            rsState_next = RS_ARMED;
          end else if (condOk) begin
            rsLoad = 1'b1;
            rsState_next = RS_DELAY;
          end
        end
        RS_ARMED: begin
          if (condOk) begin
            rsLoad = 1'b1;
            rsState_next = RS_DELAY;
          end
        end
        RS_DELAY: begin
          if (condBad) begin
            rsState_next = pulseMode ? RS_ARMED : RS_HOLD;
          end else if (rsDone && pulseMode) begin
            rsLoad = 1'b1;
            rsLoadVal = 16'(RST_PULSE_MS);
            rsState_next = RS_PULSE;
          end else if (rsDone) begin
            rsState_next = RS_RELEASED;
          end
        end
        RS_PULSE: begin
          if (rsDone) begin
            rsState_next = RS_RELEASED;
          end
        end
        RS_RELEASED: begin
          if (condBad) begin
            rsState_next = pulseMode ? RS_ARMED : RS_HOLD;
          end
        end
      endcase
    end
  end
  assign rstAssert = rsState_next == RS_HOLD || rsState_next == RS_PULSE
                     || (rsState_next == RS_DELAY && !pulseMode);

  ssv_down_timer #(.W(16)) rsTimer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(rsLoad),
    .loadVal(rsLoadVal),
    .tick(msTick),
    .done(rsDone)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rsState_reg <= RS_HOLD;
      sysRstN_reg <= 1'b0;
    end else begin
      rsState_reg <= rsState_next;
      sysRstN_reg <= !rstAssert;
    end
  end

  // Pins float during initialisation; sync clock alone drives in the failing loop.
  assign timeoutOut = timeoutPulse_reg;
  assign timeoutOeN = initBusy_reg;
  assign sysRstN = sysRstN_reg;
  assign sysRstOeN = initBusy_reg;
  assign alertN = alertN_reg;
  assign alertOeN = initBusy_reg;
  assign syncClkOut = syncClk_reg;
  assign syncClkOeN = !fwFailLoop_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_tmo_pulse;
    timeoutOut ##1 !timeoutOut;
  endsequence

  AST_KICK_RELOAD: assert property (
    (wdState_reg == WD_RUN && kick && ctrl_reg[CTRL_WD_EN] && !initBusy_reg
     && wdTimeout_reg > 16'h0002) |=> !timeoutOut [*2])
    else $error("Kick did not restart the watchdog count.");
  AST_TMO_PULSE: assert property (
    (wdState_reg == WD_RUN && wdDone && !kick && ctrl_reg[CTRL_WD_EN] && !initBusy_reg)
    |=> s_tmo_pulse)
    else $error("Timeout did not give a one-cycle pulse.");
  AST_STOPPED: assert property (
    (wdState_reg == WD_STOP && !kick && ctrl_reg[CTRL_WD_EN] && !initBusy_reg)
    |=> wdState_reg == WD_STOP && !timeoutOut)
    else $error("Watchdog left the stopped state without a kick.");
  AST_INIT_HIZ: assert property (
    initBusy_reg |-> timeoutOeN && sysRstOeN && alertOeN)
    else $error("A pin was driven during initialisation.");
  AST_RST_DROP: assert property (
    (rsState_reg == RS_RELEASED && condBad && !pulseMode && !initBusy_reg) |=> !sysRstN)
    else $error("Reset did not assert on a dropped condition.");
  AST_RECONF: assert property (
    reconfig |=> !sysRstN && rsState_reg == RS_HOLD)
    else $error("Reconfiguration did not assert reset.");
  AST_ALERT: assert property (
    (|sticky_reg) |=> !alertN)
    else $error("Alert not asserted while a flag is set.");
  AST_FW_RETRY: assert property (
    (initEnd && !fwSumOk) |=> initBusy_reg && startPend_reg && fwFailLoop_reg)
    else $error("Firmware failure did not restart initialisation.");
  AST_CFG_DISCARD: assert property (
    (initEnd && fwSumOk && !cfgSumOk) |=> ctrl_reg == CTRL_RESET && sticky_reg[ST_CFG_FAIL])
    else $error("Configuration not discarded on a bad sum.");
  AST_BUS_ACK: assert property (
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("Bus request not answered in one cycle.");
endmodule
`default_nettype wire

// ===== ssv_host_model.sv
// Host processor model: toggles the watchdog kick pin and counts timeout request cycles.
`default_nettype none
module ssv_host_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic kickEn,
  input wire logic timeoutOut,
  output logic kickIn,
  output int pulseCycles = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] gapCnt;
  // Toggle the kick pin every eight cycles, well inside the shortest timeout used.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gapCnt <= 3'h0;
      kickIn <= 1'b0;
    end else if (kickEn) begin
      gapCnt <= gapCnt + 3'h1;
      if (gapCnt == 3'h7) kickIn <= ~kickIn;
    end
  end
  // Count high cycles, so a stretched pulse shows up as more than one per timeout.
  always @(posedge ref_clk) begin
    if (timeoutOut === 1'b1) pulseCycles <= pulseCycles + 1;
  end
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the supervisor: bus, watchdog, system reset and startup checks.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ssv_pkg::*;
  localparam int TK = 4;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, timeoutOut, timeoutOeN, sysRstN, sysRstOeN, w;
  logic syncClkOut, syncClkOeN, alertN, alertOeN, kickIn;
  logic fwSumOk = 1'b1;
  logic cfgSumOk = 1'b1;
  logic [7:0] logSumOk = 8'hff;
  logic [7:0] railAboveOn = 8'h00;
  logic [7:0] railBelowOff = 8'h00;
  logic [7:0] gpiIn = 8'h01;
  logic kickEn = 1'b0;
  int pulseCycles, n;
  int mismatches = 0;
  int comparisons = 0;
  logic [4:0] cfgAddr [5] = '{ADDR_CTRL, ADDR_WD_TIMEOUT, ADDR_WD_START, ADDR_RST_DELAY, ADDR_SEL};
  logic [15:0] cfgDef [5] = '{16'(CTRL_RESET), WD_TIMEOUT_RESET, WD_START_RESET,
    RST_DELAY_RESET, SEL_RESET};

  ssv_supervisor #(.TICK_CYCLES_P(TK)) i_ssv_supervisor (.ref_clk, .resetn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
    .avs_waitrequest, .fwSumOk, .cfgSumOk, .logSumOk, .railAboveOn, .railBelowOff, .gpiIn,
    .kickIn, .timeoutOut, .timeoutOeN, .sysRstN, .sysRstOeN, .syncClkOut, .syncClkOeN,
    .alertN, .alertOeN);
  ssv_host_model i_ssv_host_model (.ref_clk, .resetn, .kickEn, .timeoutOut, .kickIn,
    .pulseCycles);

  // Free-running 20 MHz clock.
  always #25 ref_clk = ~ref_clk;

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One bus cycle; waitrequest and read data are taken at the accepting edge, then it drops.
  task automatic bus(logic wr, logic [4:0] a, logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      w = avs_waitrequest;
      rd = avs_readdata;
    end while (w !== 1'b0 && ++n < 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (w !== 1'b0) begin
      mismatches++;
      wrap_up();
    end
  endtask

  task automatic wait_rst(logic v, int lim);
    n = 0;
    #1;
    while (sysRstN !== v && n < lim) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("sysRstN", 32'(sysRstN), 32'(v));
  endtask

  task automatic wait_sync();
    logic v;
    v = syncClkOut;
    n = 0;
    while (syncClkOut === v && n < 1100) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask

  task automatic wait_init();
    int k;
    k = 0;
    do bus(1'b0, ADDR_STATUS, 32'h0); while (rd[ST_INIT] !== 1'b0 && ++k < 200);
    if (k == 200) begin
      mismatches++;
      wrap_up();
    end
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
  endtask

  // Main sequence; each step leaves the inputs in a state the next one expects.
  initial begin
    do_reset();
    #1 check("init pins", 32'({timeoutOeN, sysRstOeN, alertOeN, sysRstN}), 32'he);
    wait_init();
    check("run pins", 32'({timeoutOeN, sysRstOeN, alertOeN}), 32'h0);
    bus(1'b1, ADDR_WD_TIMEOUT, 32'h5);
    bus(1'b1, ADDR_CTRL, 32'h1);
    kickEn <= 1'b1;
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("wd running", 32'(rd[ST_WD_RUN]), 32'h1);
    repeat (80) @(posedge ref_clk);
    check("kicked", 32'(pulseCycles), 32'h0);
    kickEn <= 1'b0;
    repeat (40) @(posedge ref_clk);
    check("timeout", 32'(pulseCycles), 32'h1);
    repeat (60) @(posedge ref_clk);
    check("stopped", 32'(pulseCycles), 32'h1);
    bus(1'b1, ADDR_KICK, 32'h1);
    repeat (40) @(posedge ref_clk);
    check("bus kick", 32'(pulseCycles), 32'h2);
    check("alert", 32'(alertN), 32'h0);
    bus(1'b1, ADDR_STATUS, 32'h2);
    repeat (3) @(posedge ref_clk);
    check("alert off", 32'(alertN), 32'h1);
    bus(1'b1, ADDR_RST_DELAY, 32'h3);
    bus(1'b1, ADDR_SEL, 32'h0101);
    repeat (30) @(posedge ref_clk);
    check("held", 32'(sysRstN), 32'h0);
    @(posedge ref_clk) railAboveOn <= 8'h01;
    wait_rst(1'b1, 30);
    check("delay", 32'(n >= 8 && n <= 16), 32'h1);
    @(posedge ref_clk) railBelowOff <= 8'h01;
    wait_rst(1'b0, 3);
    check("rail drop", n, 1);
    @(posedge ref_clk) railBelowOff <= 8'h00;
    wait_rst(1'b1, 30);
    @(posedge ref_clk) gpiIn <= 8'h00;
    wait_rst(1'b0, 3);
    check("gpi drop", n, 1);
    @(posedge ref_clk) gpiIn <= 8'h01;
    wait_rst(1'b1, 30);
    bus(1'b1, ADDR_SEL, 32'h0101);
    wait_rst(1'b0, 2);
    wait_rst(1'b1, 30);
    bus(1'b1, ADDR_CTRL, 32'h8);
    wait_rst(1'b0, 3);
    wait_rst(1'b1, 5);
    wait_rst(1'b0, 20);
    wait_rst(1'b1, 10);
    check("pulse", 32'(n >= 1 && n <= 5), 32'h1);
    // Merged watchdog with a start wait: the expiry of the wait pulls reset, then it releases.
    bus(1'b1, ADDR_WD_START, 32'h8);
    bus(1'b1, ADDR_CTRL, 32'h7);
    wait_rst(1'b1, 30);
    wait_rst(1'b0, 30);
    check("start wait", 32'(n >= 12), 32'h1);
    wait_rst(1'b1, 30);
    check("merge pulse", 32'(pulseCycles), 32'h3);
    @(posedge ref_clk) cfgSumOk <= 1'b0;
    logSumOk <= 8'hf5;
    do_reset();
    // Settings written during initialisation must still be dropped when the sum is bad.
    foreach (cfgAddr[i]) begin
      bus(1'b1, cfgAddr[i], 32'(cfgDef[i] ^ 16'h0010));
      bus(1'b0, cfgAddr[i], 32'h0);
      check("written", rd, 32'(cfgDef[i] ^ 16'h0010));
    end
    wait_init();
    foreach (cfgAddr[i]) begin
      bus(1'b0, cfgAddr[i], 32'h0);
      check("discarded", rd, 32'(cfgDef[i]));
    end
    bus(1'b0, ADDR_LOG_VALID, 32'h0);
    check("log valid", rd, 32'hf5);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("flags", 32'(rd[3:0]), 32'h5);
    check("cfg alert", 32'(alertN), 32'h0);
    bus(1'b1, ADDR_STATUS, 32'h5);
    repeat (3) @(posedge ref_clk);
    check("cleared", 32'(alertN), 32'h1);
    @(posedge ref_clk) fwSumOk <= 1'b0;
    do_reset();
    n = 0;
    while (syncClkOeN !== 1'b0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    check("sync oe", 32'(syncClkOeN), 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("fw flag", 32'(rd[ST_FW_FAIL]), 32'h1);
    wait_sync();
    wait_sync();
    check("sync width", n, SYNC_PULSE_MS * TK);
    wrap_up();
  end
endmodule
`default_nettype wire
